// ==== dv/channel_ctl_refclk_twowire_regs_tb.sv ====
// Self-checking testbench for the channel control register bank.
`timescale 1ns/10ps
module channel_ctl_refclk_twowire_regs_tb;
    import chan_regs_pkg::*;
    logic        clk_sys;
    logic        rst_b;
    reg_req_s    req;
    logic [15:0] rdata;
    logic [1:0]  path_sel;
    logic [31:0] path_word_in;
    logic [31:0] path_word_out;
    logic [3:0]  path_reset;
    logic [2:0]  refclk_rate_select;
    logic        scl_line;
    logic        sda_line;
    logic        scl_out;
    logic        scl_oe_b;
    logic        sda_out;
    logic        sda_oe_b;
    logic        hold_scl_low;
    logic        hold_sda_low;
    logic [31:0] word;
    int          fails;
    int          total_checks;
    int          i;
    int          c;

    channel_ctl_refclk_twowire_regs u_channel_ctl_refclk_twowire_regs (
        .clk_sys(clk_sys), .rst_b(rst_b), .req(req), .rdata(rdata), .path_sel(path_sel),
        .path_word_in(path_word_in), .path_word_out(path_word_out),
        .path_reset(path_reset), .refclk_rate_select(refclk_rate_select),
        .scl_in(scl_line), .scl_out(scl_out), .scl_oe_b(scl_oe_b),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe_b(sda_oe_b));

    two_wire_xcvr_model u_two_wire_xcvr_model (
        .scl_out(scl_out), .scl_oe_b(scl_oe_b), .sda_out(sda_out), .sda_oe_b(sda_oe_b),
        .hold_scl_low(hold_scl_low), .hold_sda_low(hold_sda_low),
        .scl_line(scl_line), .sda_line(sda_line));

    // ****************************************************************
    // Bus tasks and checks.
    // ****************************************************************
    // Every comparison goes through here so unknowns never pass.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One-cycle write; returns just after the edge that took it.
    task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        req <= {a, d, 1'b1, 1'b0};
        @(posedge clk_sys);
        req.wr <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe, so look there.
    task automatic reg_rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk_sys);
        req <= {a, 16'h0000, 1'b0, 1'b1};
        @(posedge clk_sys);
        req.rd <= 1'b0;
        #1;
        chk({16'h0000, rdata}, {16'h0000, exp});
    endtask

    // Independent model of the word reordering: halves, then bytes, then mirror.
    function automatic logic [31:0] ordered(input logic [31:0] w, input logic h,
                                            input logic b, input logic l);
        logic [31:0] r;
        logic [31:0] m;
        r = h ? {w[15:0], w[31:16]} : w;
        r = b ? {r[23:16], r[31:24], r[7:0], r[15:8]} : r;
        for (int k = 0; k < 32; k++) begin
            m[k] = r[31 - k];
        end
        return l ? m : r;
    endfunction

    task automatic test_done();
        $display("checks=%0d fails=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ****************************************************************
    // Clock, watchdog and test sequence.
    // ****************************************************************
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // The sequence needs well under a thousand cycles; a hang is cut off here.
    initial begin
        repeat (4000) @(posedge clk_sys);
        fails++;
        test_done();
    end

    initial begin
        rst_b = 1'b0;
        req = '0;
        path_sel = 2'h0;
        path_word_in = 32'h0;
        hold_scl_low = 1'b0;
        hold_sda_low = 1'b0;
        fails = 0;
        total_checks = 0;
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        #1;
        chk({path_reset, scl_oe_b, sda_oe_b}, 6'h3F);
        reg_rd(OFF_ENABLE, 16'h0000);
        reg_rd(OFF_TWOWIRE, 16'h00CA);
        reg_rd(OFF_REFCLK, 16'h0000);
        // Enables alone must not release a path while the global enable is off.
        reg_wr(OFF_ENABLE, 16'h00FF);
        chk(path_reset, 4'hF);
        reg_rd(OFF_ENABLE, 16'h000F);
        reg_wr(OFF_COMMAND, 16'h0008);
        reg_rd(OFF_COMMAND, 16'h0008);
        for (i = 0; i < 4; i++) begin
            reg_wr(OFF_ENABLE, 16'(1 << i));
            chk(path_reset, 4'(~(4'h1 << i)));
        end
        reg_wr(OFF_COMMAND, 16'h0000);
        chk(path_reset, 4'hF);
        // Every rate code, with unused bits 7 to 3 written as ones and bits 15 to 8 as zeros.
        for (i = 0; i < 8; i++) begin
            reg_wr(OFF_REFCLK, 16'(8'hF8 + i));
            chk(refclk_rate_select, i[2:0]);
            reg_rd(OFF_REFCLK, 16'(i));
        end
        reg_wr(8'h40, 16'hFFFF);
        reg_rd(8'h40, 16'h0000);
        // All sixteen pin-control settings; sensed levels pass the two-flop sync.
        for (i = 0; i < 16; i++) begin
            reg_wr(OFF_TWOWIRE, 16'(8'hF0 + i));
            chk({scl_oe_b, scl_out, sda_oe_b, sda_out}, i[3:0]);
            repeat (3) @(posedge clk_sys);
            reg_rd(OFF_TWOWIRE, {8'h00, i[1] | i[0], i[3] | i[2], 2'b00, i[3:0]});
        end
        reg_wr(OFF_TWOWIRE, 16'h000A);
        hold_sda_low <= 1'b1;
        repeat (3) @(posedge clk_sys);
        reg_rd(OFF_TWOWIRE, 16'h004A);
        hold_sda_low <= 1'b0;
        hold_scl_low <= 1'b1;
        repeat (3) @(posedge clk_sys);
        reg_rd(OFF_TWOWIRE, 16'h008A);
        hold_scl_low <= 1'b0;
        // Start condition: data falls while the clock line is released high.
        reg_wr(OFF_TWOWIRE, 16'h0008);
        chk({scl_line, sda_line}, 2'b10);
        reg_wr(OFF_BITORDER, 16'hFFFF);
        reg_rd(OFF_BITORDER, 16'h000F);
        reg_wr(OFF_BITORDER, 16'h0005);
        word = 32'h8001_2C3F;
        for (c = 0; c < 4; c++) begin
            reg_wr(OFF_CONFIG, {12'h000, c[1], 2'b00, c[0]});
            reg_rd(OFF_CONFIG, {12'h000, c[1], 2'b00, c[0]});
            for (i = 0; i < 4; i++) begin
                @(posedge clk_sys);
                path_sel <= i[1:0];
                path_word_in <= word;
                @(posedge clk_sys);
                #1;
                chk(path_word_out, ordered(word, c[1], c[0], ~i[0]));
            end
        end
        test_done();
    end
endmodule

// ==== dv/two_wire_xcvr_model.sv ====
// Behavioural transceiver end of the two-wire management port, pull-ups on both lines.
`timescale 1ns/10ps
module two_wire_xcvr_model (
    input  wire logic scl_out,
    input  wire logic scl_oe_b,
    input  wire logic sda_out,
    input  wire logic sda_oe_b,
    input  wire logic hold_scl_low,
    input  wire logic hold_sda_low,
    output logic      scl_line,
    output logic      sda_line
);
    // Wired-AND lines: a released line floats high, and any party pulling low wins.
    // The model never drives high, so a stuck enable shows up as a wrong sensed level.
    assign scl_line = (scl_oe_b | scl_out) & ~hold_scl_low;
    assign sda_line = (sda_oe_b | sda_out) & ~hold_sda_low;
endmodule

// ==== rtl/chan_regs_pkg.sv ====
// Constants and carrier types for the channel control register bank.
// Behaviour
// - Four enable bits: ch0 rx, ch1 rx, ch0 tx, ch1 tx; one enables.
// - A path whose enable bit is zero is held in reset.
// - Bit-order one sends or takes the 32-bit word LSB first.
// - Bit-order zero puts the word's MSB first on the line.
// - Bit-order bits map like enables: ch0 rx, ch1 rx, ch0 tx, ch1 tx.
// - Byte swap and halfword swap combine with bit order per word.
// - Three-bit field selects one of eight reference clock rates.
// - Two-wire register gives software direct pin control of the transceiver.
// - Bit 7 reads the sampled serial data pin level.
// - Bit 6 reads the sampled serial clock pin level.
// - Bit 3 zero drives clock pin with bit 2; one releases it.
// - Bit 1 zero drives data pin with bit 0; one releases it.
// - Paths run only with global enable and channel enable set.
package chan_regs_pkg;

    // ****************************************************************
    // Register offsets.
    // ****************************************************************
    localparam logic [7:0] OFF_COMMAND  = 8'h00;
    localparam logic [7:0] OFF_CONFIG   = 8'h0F;
    localparam logic [7:0] OFF_ENABLE   = 8'h10;
    localparam logic [7:0] OFF_BITORDER = 8'h16;
    localparam logic [7:0] OFF_REFCLK   = 8'h2F;
    localparam logic [7:0] OFF_TWOWIRE  = 8'h31;

    // ****************************************************************
    // Field positions and reset values.
    // ****************************************************************
    localparam int POS_GLOBAL_EN    = 3;
    localparam int POS_HALFWORD_SW  = 3;
    localparam int POS_BYTE_SW      = 0;
    localparam int POS_SDA_IN       = 7;
    localparam int POS_SCL_IN       = 6;
    localparam int POS_SCL_TRI      = 3;
    localparam int POS_SCL_OUT      = 2;
    localparam int POS_SDA_TRI      = 1;
    localparam int POS_SDA_OUT      = 0;
    localparam logic [3:0] RST_ENABLES  = 4'h0;
    localparam logic [3:0] RST_BITORDER = 4'h0;
    localparam logic [2:0] RST_REFCLK   = 3'h0;
    localparam logic [3:0] RST_TWOWIRE  = 4'hA;
    localparam logic       RST_GLOBAL   = 1'b0;

    // ****************************************************************
    // Reference clock rate codes, in kHz-free labels.
    // ****************************************************************
    typedef enum logic [2:0] {
        REF_155M52_A, REF_167M33, REF_161M13, REF_173M37,
        REF_125M, REF_156M25, REF_155M52_B, REF_166M63
    } refclk_rate_e;

    // Register bus request carrier.
    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_s;

    // Per-path word-order controls.
    typedef struct packed {
        logic lsb_first;
        logic byte_sw;
        logic half_sw;
    } word_order_s;

endpackage

// ==== rtl/channel_ctl_refclk_twowire_regs.sv ====
// Register bank for path enables, bit order, reference clock and two-wire pins.
//
// Our own choice: strobed register access.
`timescale 1ns/10ps
module channel_ctl_refclk_twowire_regs
    import chan_regs_pkg::*;
(
    input  wire logic         clk_sys,
    input  wire logic         rst_b,
    input  wire reg_req_s     req,
    output logic       [15:0] rdata,
    input  wire logic  [1:0]  path_sel,
    input  wire logic  [31:0] path_word_in,
    output logic       [31:0] path_word_out,
    output logic       [3:0]  path_reset,
    output logic       [2:0]  refclk_rate_select,
    input  wire logic         scl_in,
    output logic              scl_out,
    output logic              scl_oe_b,
    input  wire logic         sda_in,
    output logic              sda_out,
    output logic              sda_oe_b
);

    // ****************************************************************
    // Register state.
    // ****************************************************************
    logic        global_en;
    logic        byte_pair_swap;
    logic        halfword_swap;
    logic [3:0]  channel_path_enables;
    logic [3:0]  bit_order;
    logic [2:0]  refclk_sel;
    logic [3:0]  twowire_ctl;
    logic [1:0]  scl_sync;
    logic [1:0]  sda_sync;
    logic [15:0] next_rdata;
    word_order_s order_ctl;

    // Command register; clearing the global enable stops every path.
    // It gates the path enables below; it does not change what they read back.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            global_en <= RST_GLOBAL;
        end else if (req.wr && req.addr == OFF_COMMAND) begin
            global_en <= req.wdata[POS_GLOBAL_EN];
        end
    end

    // Swap configuration shared by all paths.
    // The swaps act on every path alike; only the bit order is set per path.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            byte_pair_swap <= 1'b0;
            halfword_swap  <= 1'b0;
        end else if (req.wr && req.addr == OFF_CONFIG) begin
            byte_pair_swap <= req.wdata[POS_BYTE_SW];
            halfword_swap  <= req.wdata[POS_HALFWORD_SW];
        end
    end

    // Path enables, cleared at reset so no path runs.
    // Bits above three are dropped on write and read back as zero.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            channel_path_enables <= RST_ENABLES;
        end else if (req.wr && req.addr == OFF_ENABLE) begin
            channel_path_enables <= req.wdata[3:0];
        end
    end

    // Bit-order selections, one per path in enable order.
    // The orderer picks one of these through path_sel.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            bit_order <= RST_BITORDER;
        end else if (req.wr && req.addr == OFF_BITORDER) begin
            bit_order <= req.wdata[3:0];
        end
    end

    // Reference clock rate field.
    // Upper bits are dropped; every one of the eight codes is legal.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            refclk_sel <= RST_REFCLK;
        end else if (req.wr && req.addr == OFF_REFCLK) begin
            refclk_sel <= req.wdata[2:0];
        end
    end

    // Two-wire control bits; reset leaves both tristates set, pins released.
    // Software makes a high by releasing a pin; driving high would fight the far end.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            twowire_ctl <= RST_TWOWIRE;
        end else if (req.wr && req.addr == OFF_TWOWIRE) begin
            twowire_ctl <= req.wdata[3:0];
        end
    end

    // Pin levels come from outside, so two flip-flops before use.
    // They reset to one, the idle level of the pulled-up lines, so software
    // never sees a false low just after reset.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
        end else begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
        end
    end

    // ****************************************************************
    // Outputs.
    // ****************************************************************
    // A path runs only with both its own and the global enable. Clearing the
    // global enable drops every path at once, so software can stop all traffic
    // without touching the four enable bits.
    genvar p;
    generate
        for (p = 0; p < 4; p++) begin : g_path
            assign path_reset[p] = ~(channel_path_enables[p] & global_en);

            // Writing a zero enable bit must put that path into reset next cycle.
            path_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
                (req.wr && req.addr == OFF_ENABLE && !req.wdata[p]) |=> path_reset[p])
                else $error("cleared path left running");
        end
    endgenerate

    // The code leaves undecoded; the clock source maps it to a rate.
    assign refclk_rate_select = refclk_sel;

    // Pin drive; the enable is active low, matching the tristate bits.
    // Reset leaves both enables high, so nothing is driven until software asks.
    assign scl_out  = twowire_ctl[POS_SCL_OUT];
    assign scl_oe_b = twowire_ctl[POS_SCL_TRI];
    assign sda_out  = twowire_ctl[POS_SDA_OUT];
    assign sda_oe_b = twowire_ctl[POS_SDA_TRI];

    // Selected path controls; the orderer serves whichever path path_sel names,
    // held in reset or not, so software can try a setting before enabling it.
    always_comb begin
        order_ctl.lsb_first = bit_order[path_sel];
        order_ctl.byte_sw   = byte_pair_swap;
        order_ctl.half_sw   = halfword_swap;
    end

    // The orderer registers its output, so a word shows one cycle after it enters.
    word_orderer u_orderer (
        .clk_sys  (clk_sys),
        .rst_b    (rst_b),
        .ctl      (order_ctl),
        .word_in  (path_word_in),
        .word_out (path_word_out)
    );

    // ****************************************************************
    // Read port: data one cycle after the strobe, zero elsewhere.
    // ****************************************************************
    // Unmapped offsets and unused bits read as zero.
    always_comb begin
        next_rdata = 16'h0000;
        unique case (req.addr)
            OFF_COMMAND:  next_rdata[POS_GLOBAL_EN] = global_en;
            OFF_CONFIG: begin
                next_rdata[POS_BYTE_SW]     = byte_pair_swap;
                next_rdata[POS_HALFWORD_SW] = halfword_swap;
            end
            OFF_ENABLE:   next_rdata[3:0] = channel_path_enables;
            OFF_BITORDER: next_rdata[3:0] = bit_order;
            OFF_REFCLK:   next_rdata[2:0] = refclk_sel;
            OFF_TWOWIRE: begin
                next_rdata[3:0]        = twowire_ctl;
                next_rdata[POS_SDA_IN] = sda_sync[1];
                next_rdata[POS_SCL_IN] = scl_sync[1];
            end
            default:      next_rdata = 16'h0000;
        endcase
    end

    // Read data stand for one cycle only and then return to zero, so a stale
    // value can never be taken for a fresh read.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rdata <= 16'h0000;
        end else if (req.rd) begin
            rdata <= next_rdata;
        end else begin
            rdata <= 16'h0000;
        end
    end

    // ****************************************************************
    // Checks: register writes and reads.
    // ****************************************************************
    // Clearing the global enable must drop every path on the next edge.
    enable_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (req.wr && req.addr == OFF_COMMAND && !req.wdata[POS_GLOBAL_EN])
        |=> path_reset == 4'hF) else $error("paths run without global enable");
    global_read_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (req.rd && req.addr == OFF_COMMAND) |=> rdata[POS_GLOBAL_EN] == $past(global_en))
        else $error("global enable read wrong");

    // Enable bits land as written and read back with zeros above them.
    enable_write_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (req.wr && req.addr == OFF_ENABLE) |=> channel_path_enables == $past(req.wdata[3:0]))
        else $error("enable write lost");
    enable_read_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (req.rd && req.addr == OFF_ENABLE) |=> rdata == {12'h000, $past(channel_path_enables)})
        else $error("enable read wrong");
    // No path whose own enable is clear may ever be out of reset.
    path_reset_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (~channel_path_enables & ~path_reset) == 4'h0) else $error("disabled path not reset");

    // Bit-order bits land as written, one per path in enable order.
    order_write_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (req.wr && req.addr == OFF_BITORDER) |=> bit_order == $past(req.wdata[3:0]))
        else $error("bit order write lost");
    order_read_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (req.rd && req.addr == OFF_BITORDER) |=> rdata == {12'h000, $past(bit_order)})
        else $error("bit order read wrong");

    // The rate code reaches its output and reads back with zeros above it.
    refclk_out_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (req.wr && req.addr == OFF_REFCLK) |=> refclk_rate_select == $past(req.wdata[2:0]))
        else $error("refclk field lost");
    refclk_read_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (req.rd && req.addr == OFF_REFCLK) |=> rdata == {13'h0000, $past(refclk_sel)})
        else $error("refclk read wrong");

    // ****************************************************************
    // Checks: word ordering through the orderer's register stage.
    // ****************************************************************
    // With no swaps, LSB first mirrors the word and MSB first passes it as is.
    bit_order_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (!byte_pair_swap && !halfword_swap && order_ctl.lsb_first)
        |=> path_word_out[0] == $past(path_word_in[31])) else $error("lsb first wrong");
    msb_order_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (!byte_pair_swap && !halfword_swap && !order_ctl.lsb_first)
        |=> path_word_out == $past(path_word_in)) else $error("msb first wrong");
    // The selected path's own bit-order bit decides which end lands on top.
    order_map_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (!byte_pair_swap && !halfword_swap) |=> path_word_out[31] ==
        ($past(bit_order[path_sel]) ? $past(path_word_in[0]) : $past(path_word_in[31])))
        else $error("order map wrong");
    // Swaps move whole halves and whole bytes, never the bits inside them.
    half_swap_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (halfword_swap && !byte_pair_swap && !order_ctl.lsb_first)
        |=> path_word_out[15:0] == $past(path_word_in[31:16])) else $error("swap wrong");
    byte_swap_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (byte_pair_swap && !halfword_swap && !order_ctl.lsb_first)
        |=> path_word_out[15:8] == $past(path_word_in[7:0])) else $error("byte swap wrong");

    // ****************************************************************
    // Checks: two-wire pins.
    // ****************************************************************
    // Control bits land as written and read back in the low nibble.
    port_write_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (req.wr && req.addr == OFF_TWOWIRE) |=> twowire_ctl == $past(req.wdata[3:0]))
        else $error("port write lost");
    port_read_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (req.rd && req.addr == OFF_TWOWIRE) |=> rdata[3:0] == $past(twowire_ctl))
        else $error("port read wrong");
    // Level and active-low enable reach each pin on the edge after the write.
    scl_drive_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (req.wr && req.addr == OFF_TWOWIRE) |=> scl_oe_b == $past(req.wdata[POS_SCL_TRI])
        && scl_out == $past(req.wdata[POS_SCL_OUT])) else $error("scl drive wrong");
    sda_drive_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (req.wr && req.addr == OFF_TWOWIRE) |=> sda_oe_b == $past(req.wdata[POS_SDA_TRI])
        && sda_out == $past(req.wdata[POS_SDA_OUT])) else $error("sda drive wrong");
    // Sensed levels pass exactly two flops before software may see them.
    sda_sync_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        sda_sync[1] == $past(sda_in, 2)) else $error("sda sync delay wrong");
    scl_sync_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        scl_sync[1] == $past(scl_in, 2)) else $error("scl sync delay wrong");
    sda_read_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (req.rd && req.addr == OFF_TWOWIRE) |=> rdata[POS_SDA_IN] == $past(sda_sync[1]))
        else $error("sda sense wrong");
    scl_read_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (req.rd && req.addr == OFF_TWOWIRE) |=> rdata[POS_SCL_IN] == $past(scl_sync[1]))
        else $error("scl sense wrong");

    // After reset every path is held and both pins are released.
    reset_idle_a: assert property (@(posedge clk_sys)
        !rst_b |=> (scl_oe_b && sda_oe_b && path_reset == 4'hF)) else $error("reset not idle");

    // ****************************************************************
    // Coverage of the main scenarios.
    // ****************************************************************
    path_run_c: cover property (@(posedge clk_sys) disable iff (!rst_b) path_reset == 4'h0);
    pin_drive_c: cover property (@(posedge clk_sys) disable iff (!rst_b) !scl_oe_b && !sda_oe_b);
    lsb_swap_c: cover property (@(posedge clk_sys) disable iff (!rst_b)
        order_ctl.lsb_first && byte_pair_swap && halfword_swap);
    // A start condition: data pulled low while the clock is released.
    start_cond_c: cover property (@(posedge clk_sys) disable iff (!rst_b)
        scl_oe_b && !sda_oe_b && !sda_out);
    // The global enable dropped while some path enable was still set.
    gate_drop_c: cover property (@(posedge clk_sys) disable iff (!rst_b)
        $fell(global_en) && channel_path_enables != 4'h0);

endmodule

// ==== rtl/word_orderer.sv ====
// Reorders one 32-bit data word for a channel path.
`timescale 1ns/10ps
module word_orderer
    import chan_regs_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire word_order_s ctl,
    input  wire logic [31:0] word_in,
    output logic      [31:0] word_out
);
    logic [31:0] swapped;
    logic [31:0] ordered;

    // Halfword then byte swap; bits inside a byte stay put.
    always_comb begin
        swapped = ctl.half_sw ? {word_in[15:0], word_in[31:16]} : word_in;
        if (ctl.byte_sw) begin
            swapped = {swapped[23:16], swapped[31:24], swapped[7:0], swapped[15:8]};
        end
    end

    // Line order: bit 31 first by default, mirrored for LSB first.
    genvar i;
    generate
        for (i = 0; i < 32; i++) begin : g_mirror
            assign ordered[i] = ctl.lsb_first ? swapped[31 - i] : swapped[i];
        end
    endgenerate

    // Registered so the data output comes from flip-flops.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            word_out <= 32'h0000_0000;
        end else begin
            word_out <= ordered;
        end
    end
endmodule
